// ---- inc/ulms_pkg.sv ----
// Package with offsets, field positions and reset values of the status block.
package ulms_pkg;

	// Register offsets on the three-bit register port.
	localparam logic [2:0] ULMS_OFS_DATA = 3'h0;
	localparam logic [2:0] ULMS_OFS_IRQ_ENABLE = 3'h1;
	localparam logic [2:0] ULMS_OFS_IRQ_FIFO = 3'h2;
	localparam logic [2:0] ULMS_OFS_LINE_CONTROL = 3'h3;
	localparam logic [2:0] ULMS_OFS_MODEM_CONTROL = 3'h4;
	localparam logic [2:0] ULMS_OFS_LINE_STATUS = 3'h5;
	localparam logic [2:0] ULMS_OFS_MODEM_STATUS = 3'h6;
	localparam logic [2:0] ULMS_OFS_SCRATCHPAD = 3'h7;

	// Field positions in line_control.
	localparam int ULMS_LC_BREAK = 6;
	localparam int ULMS_LC_DIV_ACCESS = 7;

	// Field positions in modem_control.
	localparam int ULMS_MC_TERM_READY = 0;
	localparam int ULMS_MC_SEND_REQUEST = 1;
	localparam int ULMS_MC_USER_OUT1 = 2;
	localparam int ULMS_MC_USER_OUT2 = 3;
	localparam int ULMS_MC_LOOP = 4;
	localparam int ULMS_MC_WIDTH = 5;

	// Field positions in irq_enable.
	localparam int ULMS_IE_RX_DATA = 0;
	localparam int ULMS_IE_TX_EMPTY = 1;
	localparam int ULMS_IE_LINE = 2;
	localparam int ULMS_IE_MODEM = 3;

	// Field positions in fifo_control.
	localparam int ULMS_FC_ENABLE = 0;
	localparam int ULMS_FC_DMA_MODE = 3;

	// Reset values.
	localparam logic [7:0] ULMS_RST_BYTE = 8'h00;
	localparam logic [3:0] ULMS_RST_NIBBLE = 4'h0;
	localparam logic [ULMS_MC_WIDTH-1:0] ULMS_RST_MC = 5'h00;
	localparam logic ULMS_RST_THRE = 1'b1;

	// Interrupt source codes shown in irq_status bits 3 to 0.
	localparam logic [3:0] ULMS_ISR_NONE = 4'h1;
	localparam logic [3:0] ULMS_ISR_LINE = 4'h6;
	localparam logic [3:0] ULMS_ISR_RX_DATA = 4'h4;
	localparam logic [3:0] ULMS_ISR_TX_EMPTY = 4'h2;
	localparam logic [3:0] ULMS_ISR_MODEM = 4'h0;

	// Whole state of the block, registered in one place.
	typedef struct packed {
		logic [7:0] irq_enable;
		logic [7:0] line_control;
		logic [ULMS_MC_WIDTH-1:0] modem_control;
		logic [7:0] fifo_control;
		logic [7:0] scratchpad;
		logic thre;
		logic overrun;
		logic [3:0] delta;
		logic [3:0] prev;
		logic primed;
		logic brk_loaded;
		logic [7:0] rdata;
		logic txd;
		logic term_ready_n;
		logic send_request_n;
		logic user_out1_n;
		logic user_out2_n;
		logic rx_dma_ready_n;
		logic tx_dma_ready_n;
		logic irq;
	} ulms_state_t;

endpackage

// ---- verilog/ulms_regs.sv ----
// Line, modem and scratchpad registers with their pins and status flags.
//
// Function
// - Break bit forces serial output low outside loop-back.
// - Top line_control bit opens divisor access.
// - modem_control bits 0,1 drive ready, request low outside loop-back.
// - modem_control bits 2,3 drive user outputs low outside loop-back.
// - Bit 4 loops back; bits 5-7 read zero.
// - Data ready reads one while characters wait.
// - Overrun sets; full FIFO is never pushed.
// - Parity error belongs to head character.
// - Framing error belongs to head character.
// - Break flagged; one break character per break.
// - Holding empty set on transfer, cleared on write.
// - Holding empty with enable raises interrupt.
// - Transmitter empty when holding and shift empty.
// - FIFO error bit while errors remain queued.
// - Change bits set on change, clear on read.
// - Clear, ready, carrier changes set change bits.
// - Ring change sets only on rising pin.
// - Upper modem_status shows inverted pins or loop.
// - Eight-bit scratchpad freely read and written.
// - Reset clears control registers, irq_status reads one.
// - Reset line_status reads 0x60, change bits cleared.
// - Reset drives modem outputs high, interrupt low.
`timescale 1ns/1ps
module ulms_regs
	import ulms_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic cs_i,
	input wire logic [2:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] ext_rdata_i,
	output logic data_rd_o,
	output logic data_wr_o,
	output logic div_access_o,
	output logic feature_access_o,
	output logic [7:0] irq_enable_o,
	output logic [7:0] line_control_o,
	output logic [7:0] fifo_control_o,
	input wire logic tx_bit_i,
	output logic tx_serial_out_o,
	input wire logic rx_serial_in_i,
	output logic rx_line_o,
	input wire logic tx_load_shift_i,
	input wire logic tx_fifo_empty_i,
	input wire logic tx_fifo_full_i,
	input wire logic tx_shift_empty_i,
	input wire logic rx_done_i,
	input wire logic rx_break_i,
	input wire logic rx_fifo_full_i,
	input wire logic rx_avail_i,
	input wire logic rx_trigger_i,
	input wire logic rx_head_parity_i,
	input wire logic rx_head_framing_i,
	input wire logic rx_head_break_i,
	input wire logic rx_err_queued_i,
	output logic rx_push_o,
	input wire logic clear_to_send_n_i,
	input wire logic peer_set_ready_n_i,
	input wire logic ring_indicate_n_i,
	input wire logic carrier_detect_n_i,
	output logic term_ready_n_o,
	output logic send_request_n_o,
	output logic user_out1_n_o,
	output logic user_out2_n_o,
	output logic rx_dma_ready_n_o,
	output logic tx_dma_ready_n_o,
	output logic irq_o
);

	ulms_state_t s_r;
	ulms_state_t s_nxt;
	logic rd_hit;
	logic wr_hit;
	logic loop;
	logic fifo_mode;
	logic [3:0] pins_act;
	logic [3:0] modem_now;
	logic [7:0] line_status;
	logic [7:0] modem_status;
	logic [3:0] irq_code;

	// Address match for a strobe on the register port.
	function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
		hit = (a == ofs);
	endfunction

	// Interrupt source code by priority: line, data, holding empty, modem.
	function automatic logic [3:0] isr_code(input logic [7:0] ie,
		input logic line_err, input logic dr, input logic thre,
		input logic [3:0] dl);
		if (ie[ULMS_IE_LINE] && line_err) begin
			isr_code = ULMS_ISR_LINE;
		end else if (ie[ULMS_IE_RX_DATA] && dr) begin
			isr_code = ULMS_ISR_RX_DATA;
		end else if (ie[ULMS_IE_TX_EMPTY] && thre) begin
			isr_code = ULMS_ISR_TX_EMPTY;
		end else if (ie[ULMS_IE_MODEM] && (|dl)) begin
			isr_code = ULMS_ISR_MODEM;
		end else begin
			isr_code = ULMS_ISR_NONE;
		end
	endfunction

	// Strobes qualified by chip select, and the current operating modes.
	assign rd_hit = cs_i && rd_i;
	assign wr_hit = cs_i && wr_i;
	assign loop = s_r.modem_control[ULMS_MC_LOOP];
	assign fifo_mode = s_r.fifo_control[ULMS_FC_ENABLE];

	// Accesses at the data and enable offsets go to the divisor when opened.
	assign div_access_o = cs_i && s_r.line_control[ULMS_LC_DIV_ACCESS]
		&& (hit(addr_i, ULMS_OFS_DATA) || hit(addr_i, ULMS_OFS_IRQ_ENABLE));
	assign feature_access_o = cs_i && s_r.line_control[ULMS_LC_DIV_ACCESS]
		&& hit(addr_i, ULMS_OFS_IRQ_FIFO);
	assign data_rd_o = rd_hit && hit(addr_i, ULMS_OFS_DATA)
		&& !s_r.line_control[ULMS_LC_DIV_ACCESS];
	assign data_wr_o = wr_hit && hit(addr_i, ULMS_OFS_DATA)
		&& !s_r.line_control[ULMS_LC_DIV_ACCESS];

	// A finished character is pushed only when the FIFO has room and it is
	// not a repeat of a break already loaded.
	assign rx_push_o = rx_done_i && !rx_fifo_full_i
		&& !(rx_break_i && s_r.brk_loaded);

	// In loop-back the receiver hears the transmitter instead of the pin.
	assign rx_line_o = loop ? tx_bit_i : rx_serial_in_i;

	// Modem inputs as active-high levels, or the control bits in loop-back.
	assign pins_act = {~carrier_detect_n_i, ~ring_indicate_n_i,
		~peer_set_ready_n_i, ~clear_to_send_n_i};
	assign modem_now = loop ? {s_r.modem_control[ULMS_MC_USER_OUT2],
		s_r.modem_control[ULMS_MC_USER_OUT1],
		s_r.modem_control[ULMS_MC_TERM_READY],
		s_r.modem_control[ULMS_MC_SEND_REQUEST]} : pins_act;

	// Line status view assembled from flags and the receive path.
	assign line_status = {rx_err_queued_i,
		s_r.thre && tx_shift_empty_i,
		s_r.thre,
		rx_head_break_i,
		rx_head_framing_i,
		rx_head_parity_i,
		s_r.overrun,
		rx_avail_i};
	assign modem_status = {modem_now, s_r.delta};

	assign irq_code = isr_code(s_r.irq_enable, |line_status[4:1],
		rx_avail_i, s_r.thre, s_r.delta);

	// Next state of every register and registered pin.
	always_comb begin
		s_nxt = s_r;
		// Control register writes, each at its own offset.
		if (wr_hit && !div_access_o && !feature_access_o) begin
			unique case (addr_i)
				ULMS_OFS_IRQ_ENABLE: begin
					s_nxt.irq_enable = wdata_i;
				end
				ULMS_OFS_IRQ_FIFO: begin
					s_nxt.fifo_control = wdata_i;
				end
				ULMS_OFS_LINE_CONTROL: begin
					s_nxt.line_control = wdata_i;
				end
				ULMS_OFS_MODEM_CONTROL: begin
					s_nxt.modem_control = wdata_i[ULMS_MC_WIDTH-1:0];
				end
				ULMS_OFS_SCRATCHPAD: begin
					s_nxt.scratchpad = wdata_i;
				end
				default: begin
				end
			endcase
		end
		// Writing line_control with the divisor bit set is always allowed.
		if (wr_hit && hit(addr_i, ULMS_OFS_LINE_CONTROL)) begin
			s_nxt.line_control = wdata_i;
		end
		// Holding empty: FIFO mode follows the FIFO, else set on transfer
		// and cleared by a CPU write, with the transfer winning a tie.
		if (fifo_mode) begin
			s_nxt.thre = tx_fifo_empty_i && !data_wr_o;
		end else if (tx_load_shift_i) begin
			s_nxt.thre = 1'b1;
		end else if (data_wr_o) begin
			s_nxt.thre = 1'b0;
		end
		// Overrun clears on a line_status read, a new overrun wins.
		if (rd_hit && hit(addr_i, ULMS_OFS_LINE_STATUS)) begin
			s_nxt.overrun = 1'b0;
		end
		if (rx_done_i && rx_fifo_full_i) begin
			s_nxt.overrun = 1'b1;
		end
		// One break character per break; the idle line rearms it.
		if (rx_line_o) begin
			s_nxt.brk_loaded = 1'b0;
		end else if (rx_push_o && rx_break_i) begin
			s_nxt.brk_loaded = 1'b1;
		end
		// Change detection; the first cycle after reset only samples.
		s_nxt.prev = modem_now;
		s_nxt.primed = 1'b1;
		if (rd_hit && hit(addr_i, ULMS_OFS_MODEM_STATUS)) begin
			s_nxt.delta = ULMS_RST_NIBBLE;
		end
		if (s_r.primed) begin
			s_nxt.delta[0] = s_nxt.delta[0] || (modem_now[0] != s_r.prev[0]);
			s_nxt.delta[1] = s_nxt.delta[1] || (modem_now[1] != s_r.prev[1]);
			s_nxt.delta[2] = s_nxt.delta[2] || (s_r.prev[2] && !modem_now[2]);
			s_nxt.delta[3] = s_nxt.delta[3] || (modem_now[3] != s_r.prev[3]);
		end
		// Read data is captured on the read strobe.
		if (rd_hit) begin
			if (div_access_o || feature_access_o || hit(addr_i, ULMS_OFS_DATA)) begin
				s_nxt.rdata = ext_rdata_i;
			end else begin
				unique case (addr_i)
					ULMS_OFS_IRQ_ENABLE: begin
						s_nxt.rdata = s_r.irq_enable;
					end
					ULMS_OFS_IRQ_FIFO: begin
						s_nxt.rdata = {{2{fifo_mode}}, 2'h0, irq_code};
					end
					ULMS_OFS_LINE_CONTROL: begin
						s_nxt.rdata = s_r.line_control;
					end
					ULMS_OFS_MODEM_CONTROL: begin
						s_nxt.rdata = {3'h0, s_r.modem_control};
					end
					ULMS_OFS_LINE_STATUS: begin
						s_nxt.rdata = line_status;
					end
					ULMS_OFS_MODEM_STATUS: begin
						s_nxt.rdata = modem_status;
					end
					ULMS_OFS_SCRATCHPAD: begin
						s_nxt.rdata = s_r.scratchpad;
					end
					default: begin
						s_nxt.rdata = ext_rdata_i;
					end
				endcase
			end
		end
		// Serial and modem pins, idle while looped back.
		s_nxt.txd = s_nxt.modem_control[ULMS_MC_LOOP] ? 1'b1 :
			(s_nxt.line_control[ULMS_LC_BREAK] ? 1'b0 : tx_bit_i);
		s_nxt.term_ready_n = !(s_nxt.modem_control[ULMS_MC_TERM_READY]
			&& !s_nxt.modem_control[ULMS_MC_LOOP]);
		s_nxt.send_request_n = !(s_nxt.modem_control[ULMS_MC_SEND_REQUEST]
			&& !s_nxt.modem_control[ULMS_MC_LOOP]);
		s_nxt.user_out1_n = !(s_nxt.modem_control[ULMS_MC_USER_OUT1]
			&& !s_nxt.modem_control[ULMS_MC_LOOP]);
		s_nxt.user_out2_n = !(s_nxt.modem_control[ULMS_MC_USER_OUT2]
			&& !s_nxt.modem_control[ULMS_MC_LOOP]);
		// DMA ready pins: mode 1 uses FIFO full and trigger level.
		if (s_nxt.fifo_control[ULMS_FC_ENABLE]
			&& s_nxt.fifo_control[ULMS_FC_DMA_MODE]) begin
			s_nxt.tx_dma_ready_n = tx_fifo_full_i;
			s_nxt.rx_dma_ready_n = !(rx_trigger_i || (!s_r.rx_dma_ready_n && rx_avail_i));
		end else begin
			s_nxt.tx_dma_ready_n = !s_nxt.thre;
			s_nxt.rx_dma_ready_n = !rx_avail_i;
		end
		// Interrupt request from the same sources as irq_status.
		s_nxt.irq = (s_nxt.irq_enable[ULMS_IE_TX_EMPTY] && s_nxt.thre)
			|| (s_nxt.irq_enable[ULMS_IE_MODEM] && (|s_nxt.delta))
			|| (s_nxt.irq_enable[ULMS_IE_RX_DATA] && rx_avail_i)
			|| (s_nxt.irq_enable[ULMS_IE_LINE] && (|line_status[4:1]));
	end

	// State register; reset values give line_status 0x60 and idle pins.
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_r.irq_enable <= ULMS_RST_BYTE;
			s_r.line_control <= ULMS_RST_BYTE;
			s_r.modem_control <= ULMS_RST_MC;
			s_r.fifo_control <= ULMS_RST_BYTE;
			s_r.scratchpad <= ULMS_RST_BYTE;
			s_r.thre <= ULMS_RST_THRE;
			s_r.overrun <= 1'b0;
			s_r.delta <= ULMS_RST_NIBBLE;
			s_r.prev <= ULMS_RST_NIBBLE;
			s_r.primed <= 1'b0;
			s_r.brk_loaded <= 1'b0;
			s_r.rdata <= ULMS_RST_BYTE;
			s_r.txd <= 1'b1;
			s_r.term_ready_n <= 1'b1;
			s_r.send_request_n <= 1'b1;
			s_r.user_out1_n <= 1'b1;
			s_r.user_out2_n <= 1'b1;
			s_r.rx_dma_ready_n <= 1'b1;
			s_r.tx_dma_ready_n <= 1'b0;
			s_r.irq <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register.
	assign rdata_o = s_r.rdata;
	assign irq_enable_o = s_r.irq_enable;
	assign line_control_o = s_r.line_control;
	assign fifo_control_o = s_r.fifo_control;
	assign tx_serial_out_o = s_r.txd;
	assign term_ready_n_o = s_r.term_ready_n;
	assign send_request_n_o = s_r.send_request_n;
	assign user_out1_n_o = s_r.user_out1_n;
	assign user_out2_n_o = s_r.user_out2_n;
	assign rx_dma_ready_n_o = s_r.rx_dma_ready_n;
	assign tx_dma_ready_n_o = s_r.tx_dma_ready_n;
	assign irq_o = s_r.irq;

	// A break held in line_control keeps the serial output low outside loop-back.
	break_low_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		s_r.line_control[ULMS_LC_BREAK] && !loop |-> !tx_serial_out_o)
		else $error("Serial output not low during break.");

	// Terminal ready pin follows bit 0 outside loop-back.
	term_ready_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		term_ready_n_o == !(s_r.modem_control[ULMS_MC_TERM_READY] && !loop))
		else $error("Terminal ready pin disagrees with modem_control.");

	// Reading modem_control shows zero in bits 7 to 5.
	mc_upper_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		rd_hit && hit(addr_i, ULMS_OFS_MODEM_CONTROL) |=> rdata_o[7:5] == 3'h0)
		else $error("Unused modem_control bits read nonzero.");

	// A character into a full FIFO sets overrun and is not pushed.
	overrun_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		rx_done_i && rx_fifo_full_i |-> !rx_push_o ##1 s_r.overrun)
		else $error("Overrun not flagged or full FIFO pushed.");

	// A CPU write in character mode with no transfer in the same cycle clears holding empty next cycle.
	thre_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		data_wr_o && !fifo_mode && !tx_load_shift_i |=> !s_r.thre)
		else $error("Holding empty not cleared by write.");

	// Holding empty with its enable must hold the interrupt up.
	thre_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		s_r.thre && s_r.irq_enable[ULMS_IE_TX_EMPTY] |-> irq_o)
		else $error("Holding empty interrupt missing.");

	// A quiet modem_status read leaves all change bits cleared.
	delta_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		rd_hit && hit(addr_i, ULMS_OFS_MODEM_STATUS) && modem_now == s_r.prev
		|=> s_r.delta == ULMS_RST_NIBBLE)
		else $error("Change bits not cleared by read.");

	// A rising ring pin sets the ring change bit.
	ring_rise_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		s_r.primed && !loop && $rose(ring_indicate_n_i) |=> s_r.delta[2])
		else $error("Ring trailing edge not flagged.");

	// A falling ring pin alone never sets the ring change bit.
	ring_fall_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!loop && !s_r.delta[2] && $fell(ring_indicate_n_i) |=> !s_r.delta[2])
		else $error("Ring change set on falling pin.");

	// Scratchpad returns the byte last written to it.
	spr_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		wr_hit && hit(addr_i, ULMS_OFS_SCRATCHPAD) |=> s_r.scratchpad == $past(wdata_i))
		else $error("Scratchpad lost written byte.");

	// Modem interrupt stays up while a change bit and its enable stand.
	modem_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(|s_r.delta) && s_r.irq_enable[ULMS_IE_MODEM] |-> irq_o)
		else $error("Modem status interrupt missing.");

endmodule

// ---- verification/ulms_modem_model.sv ----
// Behavioural modem standing on the far side of the serial and handshake pins.
`timescale 1ns/1ps
module ulms_modem_model (
	input wire logic core_clk_i,
	input wire logic tx_serial_out_i,
	input wire logic term_ready_n_i,
	input wire logic send_request_n_i,
	output logic clear_to_send_n_o,
	output logic peer_set_ready_n_o,
	output logic ring_indicate_n_o,
	output logic carrier_detect_n_o,
	output logic rx_serial_in_o
);
	// Handshake pins start inactive and the receive line idles at mark.
	initial begin
		clear_to_send_n_o = 1'b1;
		peer_set_ready_n_o = 1'b1;
		ring_indicate_n_o = 1'b1;
		carrier_detect_n_o = 1'b1;
		rx_serial_in_o = 1'b1;
	end

	// Moves the pins just after an edge so the device never sees a race.
	task automatic set_pins(input logic [3:0] v);
		@(posedge core_clk_i);
		carrier_detect_n_o <= v[3];
		ring_indicate_n_o <= v[2];
		peer_set_ready_n_o <= v[1];
		clear_to_send_n_o <= v[0];
	endtask

	// Holds the receive line at a level, low for a break, high for idle.
	task automatic set_line(input logic v);
		@(posedge core_clk_i);
		rx_serial_in_o <= v;
	endtask
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the line, modem and scratchpad registers.
`timescale 1ns/1ps
module testbench;
	import ulms_pkg::*;
	logic core_clk_i, rst_b_i, cs_i, rd_i, wr_i, data_wr_o, div_access_o;
	logic [2:0] addr_i;
	logic [7:0] wdata_i, rdata_o, d, e;
	logic tx_bit_i, tx_serial_out_o, rx_serial_in_i, rx_line_o;
	logic tx_load_shift_i, tx_fifo_empty_i, tx_shift_empty_i, rx_push_o;
	logic rx_done_i, rx_break_i, rx_fifo_full_i, rx_avail_i;
	logic rx_head_parity_i, rx_head_framing_i, rx_head_break_i;
	logic rx_err_queued_i, clear_to_send_n_i, peer_set_ready_n_i;
	logic ring_indicate_n_i, carrier_detect_n_i, term_ready_n_o;
	logic send_request_n_o, user_out1_n_o, user_out2_n_o;
	logic rx_dma_ready_n_o, tx_dma_ready_n_o, irq_o, pend, last_dw, last_da;
	logic feature_access_o, last_fa;
	logic [7:0] exp_q[$], mask_q[$];
	int err_count = 0, checked = 0, cycles = 0, seed;

	ulms_regs ulms_regs_i (
		.core_clk_i, .rst_b_i, .cs_i, .addr_i, .rd_i, .wr_i, .wdata_i,
		.rdata_o, .ext_rdata_i(8'h00), .data_rd_o(), .data_wr_o,
		.div_access_o, .feature_access_o, .irq_enable_o(),
		.line_control_o(), .fifo_control_o(), .tx_bit_i, .tx_serial_out_o,
		.rx_serial_in_i, .rx_line_o, .tx_load_shift_i, .tx_fifo_empty_i,
		.tx_fifo_full_i(1'b0), .tx_shift_empty_i, .rx_done_i, .rx_break_i,
		.rx_fifo_full_i, .rx_avail_i, .rx_trigger_i(1'b0), .rx_head_parity_i,
		.rx_head_framing_i, .rx_head_break_i, .rx_err_queued_i, .rx_push_o,
		.clear_to_send_n_i, .peer_set_ready_n_i, .ring_indicate_n_i,
		.carrier_detect_n_i, .term_ready_n_o, .send_request_n_o,
		.user_out1_n_o, .user_out2_n_o, .rx_dma_ready_n_o, .tx_dma_ready_n_o,
		.irq_o
	);

	ulms_modem_model ulms_modem_model_i (
		.core_clk_i, .tx_serial_out_i(tx_serial_out_o), .term_ready_n_i(term_ready_n_o),
		.send_request_n_i(send_request_n_o),
		.clear_to_send_n_o(clear_to_send_n_i),
		.peer_set_ready_n_o(peer_set_ready_n_i),
		.ring_indicate_n_o(ring_indicate_n_i),
		.carrier_detect_n_o(carrier_detect_n_i), .rx_serial_in_o(rx_serial_in_i)
	);

	// Free-running 250 MHz clock.
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Compares one value and reports a difference at once.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Writes one register and notes the decode strobes seen in mid-cycle.
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge core_clk_i);
		cs_i <= 1'b1;
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(negedge core_clk_i);
		last_dw = data_wr_o;
		last_da = div_access_o;
		last_fa = feature_access_o;
		@(posedge core_clk_i);
		cs_i <= 1'b0;
		wr_i <= 1'b0;
	endtask

	// Reads one register; the expected byte and mask go on the queue.
	task automatic reg_rd(input logic [2:0] a, input logic [7:0] v,
		input logic [7:0] m);
		exp_q.push_back(v & m);
		mask_q.push_back(m);
		@(posedge core_clk_i);
		cs_i <= 1'b1;
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge core_clk_i);
		cs_i <= 1'b0;
		rd_i <= 1'b0;
	endtask

	// Lets some cycles pass and lands between edges.
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask

	// Offers one received character and checks whether it is pushed.
	task automatic rx_char(input logic full, input logic brk, input logic push);
		@(posedge core_clk_i);
		rx_done_i <= 1'b1;
		rx_fifo_full_i <= full;
		rx_break_i <= brk;
		@(negedge core_clk_i);
		chk(rx_push_o, push);
		@(posedge core_clk_i);
		rx_done_i <= 1'b0;
		rx_fifo_full_i <= 1'b0;
		rx_break_i <= 1'b0;
	endtask

	task automatic endtest(input string name);
		$display("test %s done at %0t", name, $time);
	endtask

	// Read data is settled one edge after the read was taken.
	always @(posedge core_clk_i) pend <= cs_i & rd_i;
	always @(negedge core_clk_i) begin
		if (pend === 1'b1 && exp_q.size() > 0) begin
			chk(rdata_o & mask_q.pop_front(), exp_q.pop_front());
		end
	end

	// Cuts a hung run short.
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end

	// Main sequence of scenarios.
	initial begin
		seed = 37375;
		rst_b_i = 1'b0;
		{cs_i, rd_i, wr_i, tx_load_shift_i, rx_done_i, rx_break_i} = 6'h00;
		{rx_fifo_full_i, rx_avail_i, rx_head_parity_i} = 3'h0;
		{rx_head_framing_i, rx_head_break_i, rx_err_queued_i} = 3'h0;
		{tx_bit_i, tx_fifo_empty_i, tx_shift_empty_i} = 3'h7;
		addr_i = 3'h0;
		wdata_i = 8'h00;
		repeat (15) @(posedge core_clk_i);
		@(negedge core_clk_i);
		chk({term_ready_n_o, send_request_n_o, user_out1_n_o, user_out2_n_o,
			rx_dma_ready_n_o, tx_dma_ready_n_o, irq_o, tx_serial_out_o},
			8'hF9);
		@(posedge core_clk_i);
		rst_b_i <= 1'b1;
		reg_rd(ULMS_OFS_LINE_CONTROL, 8'h00, 8'hFF);
		reg_rd(ULMS_OFS_MODEM_CONTROL, 8'h00, 8'hFF);
		reg_rd(ULMS_OFS_IRQ_ENABLE, 8'h00, 8'hFF);
		reg_rd(ULMS_OFS_IRQ_FIFO, 8'h01, 8'hFF);
		reg_rd(ULMS_OFS_LINE_STATUS, 8'h60, 8'hFF);
		reg_rd(ULMS_OFS_MODEM_STATUS, 8'h00, 8'hFF);
		endtest("reset");
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			reg_wr(ULMS_OFS_SCRATCHPAD, d);
			reg_rd(ULMS_OFS_SCRATCHPAD, d, 8'hFF);
		end
		reg_rd(ULMS_OFS_LINE_CONTROL, 8'h00, 8'hFF);
		endtest("scratchpad");
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			tx_bit_i <= d[5];
			reg_wr(ULMS_OFS_MODEM_CONTROL, d);
			reg_rd(ULMS_OFS_MODEM_CONTROL, d & 8'h1F, 8'hFF);
			e = d[4] ? 8'h0F : {4'h0, ~d[3:0]};
			chk({4'h0, user_out2_n_o, user_out1_n_o, send_request_n_o,
				term_ready_n_o}, e);
			chk({6'h00, tx_serial_out_o, rx_line_o},
				{6'h00, d[4] | d[5], d[4] ? d[5] : 1'b1});
			if (d[4]) begin
				reg_rd(ULMS_OFS_MODEM_STATUS, {d[3], d[2], d[0], d[1], 4'h0},
					8'hF0);
			end
		end
		reg_wr(ULMS_OFS_MODEM_CONTROL, 8'h00);
		reg_rd(ULMS_OFS_MODEM_STATUS, 8'h00, 8'hF0);
		endtest("modem control");
		tx_bit_i <= 1'b1;
		reg_wr(ULMS_OFS_LINE_CONTROL, 8'h40);
		idle(2);
		chk(tx_serial_out_o, 1'b0);
		reg_wr(ULMS_OFS_LINE_CONTROL, 8'h80);
		idle(2);
		chk(tx_serial_out_o, 1'b1);
		reg_wr(ULMS_OFS_DATA, 8'h5A);
		chk({last_dw, last_da}, 2'b01);
		reg_wr(ULMS_OFS_IRQ_FIFO, 8'h01);
		chk({last_fa, last_da}, 2'b10);
		reg_rd(ULMS_OFS_LINE_CONTROL, 8'h80, 8'hFF);
		reg_wr(ULMS_OFS_LINE_CONTROL, 8'h00);
		endtest("break and divisor");
		reg_wr(ULMS_OFS_IRQ_ENABLE, 8'h02);
		idle(2);
		chk(irq_o, 1'b1);
		reg_rd(ULMS_OFS_IRQ_FIFO, 8'h02, 8'hFF);
		reg_wr(ULMS_OFS_DATA, 8'hA5);
		chk({last_dw, last_da}, 2'b10);
		idle(2);
		chk(irq_o, 1'b0);
		reg_rd(ULMS_OFS_LINE_STATUS, 8'h00, 8'h60);
		@(posedge core_clk_i);
		tx_load_shift_i <= 1'b1;
		tx_shift_empty_i <= 1'b0;
		@(posedge core_clk_i);
		tx_load_shift_i <= 1'b0;
		reg_rd(ULMS_OFS_LINE_STATUS, 8'h20, 8'h60);
		tx_shift_empty_i <= 1'b1;
		reg_rd(ULMS_OFS_LINE_STATUS, 8'h60, 8'h60);
		idle(1);
		chk(irq_o, 1'b1);
		reg_wr(ULMS_OFS_IRQ_ENABLE, 8'h00);
		endtest("transmit empty");
		reg_wr(ULMS_OFS_IRQ_FIFO, 8'h01);
		reg_rd(ULMS_OFS_IRQ_FIFO, 8'hC1, 8'hFF);
		tx_fifo_empty_i <= 1'b0;
		reg_rd(ULMS_OFS_LINE_STATUS, 8'h00, 8'h20);
		tx_fifo_empty_i <= 1'b1;
		reg_rd(ULMS_OFS_LINE_STATUS, 8'h20, 8'h20);
		reg_wr(ULMS_OFS_IRQ_FIFO, 8'h00);
		endtest("fifo mode");
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			rx_avail_i <= d[0];
			{rx_err_queued_i, rx_head_break_i, rx_head_framing_i,
				rx_head_parity_i} <= d[4:1];
			reg_rd(ULMS_OFS_LINE_STATUS, {d[4], 2'b11, d[3:1], 1'b0, d[0]},
				8'hFF);
		end
		rx_avail_i <= 1'b0;
		{rx_err_queued_i, rx_head_break_i, rx_head_framing_i,
			rx_head_parity_i} <= 4'h0;
		rx_char(1'b0, 1'b0, 1'b1);
		rx_char(1'b1, 1'b0, 1'b0);
		reg_rd(ULMS_OFS_LINE_STATUS, 8'h02, 8'h02);
		reg_rd(ULMS_OFS_LINE_STATUS, 8'h00, 8'h02);
		ulms_modem_model_i.set_line(1'b0);
		rx_char(1'b0, 1'b1, 1'b1);
		rx_char(1'b0, 1'b1, 1'b0);
		ulms_modem_model_i.set_line(1'b1);
		rx_char(1'b0, 1'b1, 1'b1);
		endtest("line status");
		reg_wr(ULMS_OFS_IRQ_ENABLE, 8'h08);
		ulms_modem_model_i.set_pins(4'h0);
		idle(3);
		chk(irq_o, 1'b1);
		reg_rd(ULMS_OFS_MODEM_STATUS, 8'hFB, 8'hFF);
		idle(2);
		chk(irq_o, 1'b0);
		reg_rd(ULMS_OFS_MODEM_STATUS, 8'hF0, 8'hFF);
		ulms_modem_model_i.set_pins(4'h4);
		idle(3);
		chk(irq_o, 1'b1);
		reg_rd(ULMS_OFS_MODEM_STATUS, 8'hB4, 8'hFF);
		endtest("modem status");
		idle(4);
		complete_run();
	end
endmodule
